// File: hw/asc_sequencer_control.sv
// Top of the converter sequencer: register file on Avalon-MM, pin function
// selection, converter clock divider, start/reset control, done flag and irq.
// Assumes one 20 MHz clock, a synchronous active-low reset and an analog
// front end that follows channelSel, sampleHold and trialCode.
// Register fields sit in bits 7:0 of each word; the upper bits read as zero.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns

module asc_sequencer_control (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Avalon-MM register slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Interrupt
   output logic             irq,
   // Analog front end
   input  wire logic        compGe,
   output logic [1:0]       channelSel,
   output logic             converterPowerDown,
   output logic             converterReset,
   output logic             sampleHold,
   output logic [11:0]      trialCode,
   // Shared port pins
   input  wire logic [3:0]  portDirIn,
   input  wire logic [3:0]  pullupCfg,
   output logic [3:0]       analogPin,
   output logic [3:0]       portDirOut,
   output logic [3:0]       pullupOn
);

   // ==========================================================
   // Helper functions.

   // Pins below the configured count become analog; codes past four
   // saturate at all four so that no code leaves a pin half assigned.
   function automatic logic [3:0] analog_mask(input logic [2:0] pcr);
      logic [3:0] m;
      m = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (3'(i) < pcr) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   function automatic logic [5:0] divide_ratio(input logic [1:0] sel);
      logic [5:0] r;
      r = 6'h00;
      unique case (sel)
         asc_pkg::CLKSEL_DIV2:  r = asc_pkg::RATIO_DIV2;
         asc_pkg::CLKSEL_DIV8:  r = asc_pkg::RATIO_DIV8;
         asc_pkg::CLKSEL_DIV32: r = asc_pkg::RATIO_DIV32;
         default:               r = 6'h00;
      endcase
      return r;
   endfunction

   // Exact byte offset match: unmapped or misaligned addresses select
   // nothing, so they read as zero and writes to them are dropped.
   function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] off);
      return (addr == off);
   endfunction

   // ==========================================================
   // Register state.

   // Control fields and the start edge waiting to reach the engine.
   logic        ctlStart;
   logic [2:0]  ctlPcr;
   logic [1:0]  ctlAcs;
   logic        goPend;
   logic [1:0]  clkSel;

   // Completion: done flag, result bytes and interrupt bits.
   logic        doneN;
   logic [3:0]  resLow;
   logic [7:0]  resHigh;
   logic        irqStatus;
   logic        irqMask;

   // Converter clock divider.
   logic [5:0]  divCnt;

   // ==========================================================
   // Bus decode.
   wire         reqTake   = (read || write) && waitrequest;
   // A write lands on the edge at which the master sees waitrequest low.
   wire         wrAccept  = write && !waitrequest;
   wire         selResLo  = reg_hit(address, asc_pkg::OFF_RESULT_LOW);
   wire         selResHi  = reg_hit(address, asc_pkg::OFF_RESULT_HIGH);
   wire         selCtl    = reg_hit(address, asc_pkg::OFF_CONTROL);
   wire         selClk    = reg_hit(address, asc_pkg::OFF_CLOCK_SELECT);
   wire         selIrqSt  = reg_hit(address, asc_pkg::OFF_IRQ_STATUS);
   wire         selIrqMk  = reg_hit(address, asc_pkg::OFF_IRQ_MASK);
   wire         wrCtl     = wrAccept && selCtl;
   wire         wrClk     = wrAccept && selClk;
   wire         wrIrqSt   = wrAccept && selIrqSt;
   wire         wrIrqMk   = wrAccept && selIrqMk;
   wire         newStart  = writedata[asc_pkg::CTL_START_BIT];
   // Write data fields, named as they are stored.
   wire  [2:0]  newPcr    = writedata[asc_pkg::CTL_PCR_LSB +: 3];
   wire  [1:0]  newAcs    = writedata[asc_pkg::CTL_ACS_LSB +: 2];
   wire  [1:0]  newClkSel = writedata[1:0];
   wire         newMask   = writedata[asc_pkg::IRQ_DONE_BIT];
   wire         clrIrq    = wrIrqSt && writedata[asc_pkg::IRQ_DONE_BIT];

   // ==========================================================
   // Start sequencing.
   wire         startRise = wrCtl && newStart && !ctlStart;
   wire         startFall = wrCtl && !newStart && ctlStart;
   wire         poweredDn = (ctlPcr == 3'h0);
   // Converter held in reset while start stays high or it is powered down.
   wire         engHold   = ctlStart || poweredDn;
   // The start edge is acted on one cycle later, once the new field values
   // are stored, so a write that lowers start and sets the pins acts as one.
   wire         engGo     = goPend && !engHold;

   // ==========================================================
   // Converter clock divider.
   wire  [5:0]  ratio     = divide_ratio(clkSel);
   // Invalid select gives no ticks, so a conversion stalls with the flag high.
   wire         ratioOk   = (ratio != 6'h00);
   wire         tick      = ratioOk && (divCnt == ratio - 6'h01);

   // ==========================================================
   // Engine and read mux.
   wire         engDone;
   wire  [11:0] engResult;
   wire  [3:0]  pinMask   = analog_mask(ctlPcr);
   // Pin config reads back from bits 5:3, where it is written; bit 2 reads zero.
   wire  [7:0]  ctlRead   = {ctlStart, doneN, ctlPcr, 1'b0, ctlAcs};
   wire  [7:0]  resLoRead = {resLow, 4'h0};
   wire  [31:0] rdMux     = selResLo ? {24'h000000, resLoRead} :
                            selResHi ? {24'h000000, resHigh} :
                            selCtl   ? {24'h000000, ctlRead} :
                            selClk   ? {30'h00000000, clkSel} :
                            selIrqSt ? {31'h00000000, irqStatus} :
                            selIrqMk ? {31'h00000000, irqMask} :
                                       32'h00000000;

   // The engine's busy flag is left open: the done flag and sampleHold say enough.
   asc_sar_engine u_engine (
      .clk        (clk),
      .rstn       (rstn),
      .tick       (tick),
      .hold       (engHold),
      .go         (engGo),
      .compGe     (compGe),
      .trialCode  (trialCode),
      .sampleHold (sampleHold),
      .busy       (),
      .done       (engDone),
      .result     (engResult)
   );

   // ==========================================================
   // Avalon-MM handshake: one wait cycle, then the answer. Waitrequest idles
   // high, so a request is never completed on the edge that raises it, and
   // the low cycle that follows is never taken as a second request.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !reqTake;
      end
   end

   // Read data is captured once per read and then stands until the next read.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         readdata <= 32'h00000000;
      end else if (reqTake && read) begin
         readdata <= rdMux;
      end
   end

   // ==========================================================
   // Start bit and the pending go. The go waits one cycle so that the engine
   // sees the field values that the same write stored.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctlStart <= 1'b0;
         goPend   <= 1'b0;
      end else begin
         goPend <= startFall;
         if (wrCtl) begin
            ctlStart <= newStart;
         end
      end
   end

   // ==========================================================
   // Pin and channel fields. Pin function follows the field only, at any time.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctlPcr <= asc_pkg::PCR_RESET;
         ctlAcs <= asc_pkg::ACS_RESET;
      end else if (wrCtl) begin
         ctlPcr <= newPcr;
         ctlAcs <= newAcs;
      end
   end

   // ==========================================================
   // Converter clock select.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         clkSel <= asc_pkg::CLKSEL_RESET;
      end else if (wrClk) begin
         clkSel <= newClkSel;
      end
   end

   // ==========================================================
   // Divider counter restarts with each conversion for a fixed phase.
   // An invalid select keeps it at zero, so a later valid one starts clean.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         divCnt <= 6'h00;
      end else if (engHold || engGo || tick || !ratioOk) begin
         divCnt <= 6'h00;
      end else begin
         divCnt <= divCnt + 6'h01;
      end
   end

   // ==========================================================
   // Done flag. Any start activity forces it high, so a flag left low by an
   // earlier conversion, or by a channel change, can never pass for a new
   // result.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         doneN <= asc_pkg::DONE_N_RESET;
      end else if (startRise || ctlStart || goPend) begin
         doneN <= 1'b1;
      end else if (engDone) begin
         doneN <= 1'b0;
      end
   end

   // ==========================================================
   // Result bytes. They land on the same edge that the flag falls, so a read
   // after the fall never sees a stale half.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         resLow  <= 4'h0;
         resHigh <= 8'h00;
      end else if (engDone && !ctlStart) begin
         resHigh <= engResult[11:4];
         resLow  <= engResult[3:0];
      end
   end

   // ==========================================================
   // Interrupt status: sticky, write one to clear, and set wins over clear so
   // that an event in the clearing cycle is never lost.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irqStatus <= 1'b0;
      end else if (engDone && !ctlStart) begin
         irqStatus <= 1'b1;
      end else if (clrIrq) begin
         irqStatus <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupt mask and the level output.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irqMask <= 1'b0;
      end else if (wrIrqMk) begin
         irqMask <= newMask;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= irqStatus && irqMask;
      end
   end

   // ==========================================================
   // Pin function outputs. They follow the field at any time; software must
   // still pulse start after a change, since the flag is not refreshed here.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         analogPin  <= 4'h0;
         portDirOut <= 4'h0;
         pullupOn   <= 4'h0;
      end else begin
         analogPin  <= pinMask;
         // Analog pins are forced to input (1) whatever the direction bit.
         portDirOut <= portDirIn | pinMask;
         pullupOn   <= pullupCfg & ~pinMask;
      end
   end

   // ==========================================================
   // Converter routing and power.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         channelSel         <= asc_pkg::ACS_RESET;
         converterPowerDown <= 1'b1;
         converterReset     <= 1'b1;
      end else begin
         channelSel         <= ctlAcs;
         converterPowerDown <= poweredDn;
         converterReset     <= engHold;
      end
   end

endmodule

// File: hw/asc_pkg.sv
// Shared constants of the converter sequencer: register map, field positions,
// reset values, divider ratios and conversion phase lengths.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register port.

package asc_pkg;

   // ==========================================================
   // Register byte offsets.
   localparam logic [4:0] OFF_RESULT_LOW   = 5'h00;
   localparam logic [4:0] OFF_RESULT_HIGH  = 5'h04;
   localparam logic [4:0] OFF_CONTROL      = 5'h08;
   localparam logic [4:0] OFF_CLOCK_SELECT = 5'h0c;
   localparam logic [4:0] OFF_IRQ_STATUS   = 5'h10;
   localparam logic [4:0] OFF_IRQ_MASK     = 5'h14;

   // ==========================================================
   // Field positions.
   localparam int CTL_ACS_LSB    = 0;
   localparam int CTL_PCR_LSB    = 3;
   localparam int CTL_DONE_N_BIT = 6;
   localparam int CTL_START_BIT  = 7;
   localparam int RES_LOW_LSB    = 4;
   localparam int IRQ_DONE_BIT   = 0;

   // ==========================================================
   // Reset values.
   localparam logic       DONE_N_RESET  = 1'b1;
   localparam logic [1:0] CLKSEL_RESET  = 2'h0;
   localparam logic [2:0] PCR_RESET     = 3'h0;
   localparam logic [1:0] ACS_RESET     = 2'h0;
   localparam logic [3:0] PULLUP_ENABLE = 4'hf;

   // ==========================================================
   // Clock select codes and their divide ratios.
   localparam logic [1:0] CLKSEL_DIV32 = 2'h0;
   localparam logic [1:0] CLKSEL_DIV2  = 2'h1;
   localparam logic [1:0] CLKSEL_DIV8  = 2'h2;
   localparam logic [5:0] RATIO_DIV2   = 6'h02;
   localparam logic [5:0] RATIO_DIV8   = 6'h08;
   localparam logic [5:0] RATIO_DIV32  = 6'h20;

   // ==========================================================
   // Conversion phases, counted in converter clock ticks, and the all-analog pin code.
   localparam int         RESULT_BITS  = 12;
   localparam logic [3:0] SAMPLE_TICKS = 4'h2;
   localparam logic [2:0] PCR_ALL      = 3'h4;

endpackage

// File: hw/asc_sar_engine.sv
// Successive-approximation bit sequencer for one 12-bit conversion.
// Assumes an external comparator reports whether the sampled input is at or
// above trialCode, settled before the next converter clock tick.
`timescale 1ns/1ns

module asc_sar_engine (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Sequencing
   input  wire logic        tick,
   input  wire logic        hold,
   input  wire logic        go,
   // Comparator
   input  wire logic        compGe,
   output logic [11:0]      trialCode,
   output logic             sampleHold,
   // Result
   output logic             busy,
   output logic             done,
   output logic [11:0]      result
);

   typedef enum logic [1:0] {ASC_IDLE, ASC_SAMPLE, ASC_CONVERT} asc_phase_t;

   asc_phase_t  phase;
   logic [3:0]  bitIdx;
   logic [3:0]  sampleCnt;

   // ==========================================================
   // Trial decision.
   wire  [11:0] bitMask   = 12'h001 << bitIdx;
   wire  [11:0] nextMask  = 12'h001 << (bitIdx - 4'h1);
   wire  [11:0] keptTrial = compGe ? trialCode : (trialCode & ~bitMask);
   wire         lastBit   = (bitIdx == 4'h0);

   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (!rstn || hold) begin
         phase      <= ASC_IDLE;
         bitIdx     <= 4'h0;
         sampleCnt  <= 4'h0;
         trialCode  <= 12'h000;
         sampleHold <= 1'b0;
         busy       <= 1'b0;
         if (!rstn) begin
            result <= 12'h000;
         end
      end else begin
         unique case (phase)
            ASC_IDLE: begin
               if (go) begin
                  phase      <= ASC_SAMPLE;
                  sampleCnt  <= 4'h0;
                  sampleHold <= 1'b1;
                  busy       <= 1'b1;
               end
            end
            ASC_SAMPLE: begin
               if (tick) begin
                  sampleCnt <= sampleCnt + 4'h1;
                  if (sampleCnt == asc_pkg::SAMPLE_TICKS - 4'h1) begin
                     phase      <= ASC_CONVERT;
                     sampleHold <= 1'b0;
                     bitIdx     <= 4'(asc_pkg::RESULT_BITS - 1);
                     trialCode  <= 12'h800;
                  end
               end
            end
            ASC_CONVERT: begin
               if (tick) begin
                  if (lastBit) begin
                     result    <= keptTrial;
                     trialCode <= 12'h000;
                     done      <= 1'b1;
                     busy      <= 1'b0;
                     phase     <= ASC_IDLE;
                  end else begin
                     trialCode <= keptTrial | nextMask;
                     bitIdx    <= bitIdx - 4'h1;
                  end
               end
            end
         endcase
      end
   end

endmodule

// File: testbench/asc_seq_chk.sv
// Port checker for the converter sequencer.
// Assumes it is bound into asc_sequencer_control and sees its ports only.
`timescale 1ns/1ns

module asc_seq_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Register bus
   input wire logic [4:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        irq,
   // Converter and pins
   input wire logic        converterPowerDown,
   input wire logic        converterReset,
   input wire logic        sampleHold,
   input wire logic [3:0]  portDirIn,
   input wire logic [3:0]  pullupCfg,
   input wire logic [3:0]  analogPin,
   input wire logic [3:0]  portDirOut,
   input wire logic [3:0]  pullupOn
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // ==========================================
   // Assertions
   property p_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("bus request not answered after one wait");
   property p_pulse; !waitrequest |=> waitrequest; endproperty
   a_pulse: assert property (p_pulse) else $error("waitrequest low for more than one cycle");
   property p_upper; read && !waitrequest |-> readdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read data bits not zero");
   property p_lownib;
      read && !waitrequest && address == asc_pkg::OFF_RESULT_LOW |-> readdata[3:0] == 4'h0;
   endproperty
   a_lownib: assert property (p_lownib) else $error("unused low result bits not zero");
   property p_pins; analogPin inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}; endproperty
   a_pins: assert property (p_pins) else $error("analog pins not cumulative from pin 0");
   property p_off; converterPowerDown == (analogPin == 4'h0); endproperty
   a_off: assert property (p_off) else $error("power down does not match digital pins");
   property p_offrst; converterPowerDown |-> converterReset; endproperty
   a_offrst: assert property (p_offrst) else $error("converter not reset while powered down");
   property p_pull;
      $past(rstn) && $stable(analogPin) && $stable(pullupCfg) ##1 $stable(analogPin) && $stable(pullupCfg)
         |-> pullupOn == (pullupCfg & ~analogPin);
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up left on an analog pin");
   property p_dir;
      $past(rstn) && $stable(analogPin) && $stable(portDirIn) ##1 $stable(analogPin) && $stable(portDirIn)
         |-> portDirOut == (portDirIn | analogPin);
   endproperty
   a_dir: assert property (p_dir) else $error("analog pin direction not overridden");
   property p_irqfall; $fell(irq) |-> $past(write) || $past(write, 2) || $past(write, 3); endproperty
   a_irqfall: assert property (p_irqfall) else $error("irq dropped without a register write");

   c_irq: cover property ($rose(irq));
   c_sample: cover property ($rose(sampleHold));
   c_wake: cover property ($fell(converterPowerDown));
endmodule

bind asc_sequencer_control asc_seq_chk u_chk (.clk, .rstn, .address, .read, .write, .readdata,
   .waitrequest, .irq, .converterPowerDown, .converterReset, .sampleHold, .portDirIn,
   .pullupCfg, .analogPin, .portDirOut, .pullupOn);

// File: testbench/asc_analog_src.sv
// Analog source and comparator model on the converter's far side.
// Assumes one 12-bit level per input, packed with input 0 lowest.
`timescale 1ns/1ns

module asc_analog_src (
   // Clock
   input wire logic        clk,
   // Converter side
   input wire logic [47:0] levels,
   input wire logic [1:0]  channelSel,
   input wire logic        sampleHold,
   input wire logic        converterPowerDown,
   input wire logic [11:0] trialCode,
   output logic            compGe
);
   logic [11:0] held;
   logic        junk = 1'b0;

   always @(posedge clk) begin
      junk <= ~junk;
      if (sampleHold) begin
         held <= levels[channelSel * 12 +: 12];
      end
   end

   // A powered-down front end gives no usable answer, so it keeps changing.
   assign compGe = converterPowerDown ? junk : (held >= trialCode);
endmodule

// File: testbench/tb_asc_sequencer_control.sv
// Self-checking bench of the converter sequencer: registers, pins, conversions, irq.
// Assumes the package, the design, the checker and the analog model are compiled first.
`timescale 1ns/1ns

module tb_asc_sequencer_control;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q;
   logic        waitrequest, irq, compGe, converterPowerDown, converterReset, sampleHold;
   logic [1:0]  channelSel;
   logic [11:0] trialCode;
   logic [3:0]  portDirIn = 4'h0;
   logic [3:0]  pullupCfg = 4'hf;
   logic [3:0]  analogPin, portDirOut, pullupOn;
   logic [47:0] levels = 48'h001_fff_3f1_a5c;
   logic        shPrev = 1'b0;
   logic        irqPrev = 1'b0;
   int          badCount = 0;
   int          checks = 0;
   int          span = 0;
   int          lastSpan = 0;

   asc_sequencer_control dut (.clk, .rstn, .address, .read, .write, .writedata, .readdata,
      .waitrequest, .irq, .compGe, .channelSel, .converterPowerDown, .converterReset,
      .sampleHold, .trialCode, .portDirIn, .pullupCfg, .analogPin, .portDirOut, .pullupOn);
   asc_analog_src src (.clk, .levels, .channelSel, .sampleHold, .converterPowerDown,
      .trialCode, .compGe);

   initial begin
      forever #25 clk = ~clk;
   end

   // Cycles from the start of sampling to the rise of irq.
   always @(posedge clk) begin
      span <= (sampleHold && !shPrev) ? 0 : span + 1;
      if (irq && !irqPrev) lastSpan <= span;
      shPrev <= sampleHold;
      irqPrev <= irq;
   end

   // ==========================================
   // Shared tasks
   task automatic give_verdict;
      if (badCount == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for the answer however long it takes; only the watchdog ends a hang.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(q, e);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset;
      rd_chk(asc_pkg::OFF_CONTROL, 32'h40);
      rd_chk(asc_pkg::OFF_RESULT_LOW, 32'h0);
      rd_chk(asc_pkg::OFF_CLOCK_SELECT, 32'h0);
      rd_chk(5'h18, 32'h0);
      check(32'(converterPowerDown), 32'h1);
   endtask

   task automatic t_pins;
      logic [3:0] e;
      portDirIn <= 4'h2;
      pullupCfg <= 4'hd;
      for (int p = 7; p >= 0; p--) begin
         e = (p >= 4) ? 4'hf : 4'((1 << p) - 1);
         bus(1'b1, asc_pkg::OFF_CONTROL, 32'(p * 8 + p % 4));
         repeat (2) @(posedge clk);
         check(32'(analogPin), 32'(e));
         check(32'(portDirOut), 32'(e | 4'h2));
         check(32'(pullupOn), {28'h0, 4'hd & ~e});
         check(32'(converterPowerDown), 32'(p == 0));
         check(32'(channelSel), 32'(p % 4));
      end
   endtask

   task automatic t_convert(input logic [1:0] code, input int r, input int ch, input logic m);
      logic [11:0] v;
      int n;
      v = levels[ch * 12 +: 12];
      n = 0;
      bus(1'b1, asc_pkg::OFF_IRQ_MASK, 32'(m));
      bus(1'b1, asc_pkg::OFF_IRQ_STATUS, 32'h1);
      bus(1'b1, asc_pkg::OFF_CLOCK_SELECT, 32'(code));
      bus(1'b1, asc_pkg::OFF_CONTROL, 32'(8'ha0 + ch));
      rd_chk(asc_pkg::OFF_CONTROL, 32'(8'he0 + ch));
      check(32'(converterReset), 32'h1);
      bus(1'b1, asc_pkg::OFF_CONTROL, 32'(8'h20 + ch));
      do begin
         bus(1'b0, asc_pkg::OFF_CONTROL, 32'h0);
         n++;
      end while (q[6] !== 1'b0 && n < 400);
      check(32'(q[6]), 32'h0);
      rd_chk(asc_pkg::OFF_RESULT_HIGH, 32'(v[11:4]));
      rd_chk(asc_pkg::OFF_RESULT_LOW, {24'h0, v[3:0], 4'h0});
      rd_chk(asc_pkg::OFF_IRQ_STATUS, 32'h1);
      if (m) check(32'(lastSpan >= 13 * r && lastSpan <= 15 * r + 2), 32'h1);
   endtask

   task automatic t_irq;
      t_convert(asc_pkg::CLKSEL_DIV2, int'(asc_pkg::RATIO_DIV2), 3, 1'b0);
      check(32'(irq), 32'h0);
      bus(1'b1, asc_pkg::OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h1);
      bus(1'b1, asc_pkg::OFF_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0);
      rd_chk(asc_pkg::OFF_IRQ_STATUS, 32'h0);
      bus(1'b1, asc_pkg::OFF_RESULT_HIGH, 32'hff);
      rd_chk(asc_pkg::OFF_RESULT_HIGH, 32'h0);
   endtask

   task automatic t_stall;
      bus(1'b1, asc_pkg::OFF_CLOCK_SELECT, 32'h3);
      bus(1'b1, asc_pkg::OFF_CONTROL, 32'ha1);
      bus(1'b1, asc_pkg::OFF_CONTROL, 32'h21);
      repeat (300) @(posedge clk);
      rd_chk(asc_pkg::OFF_CONTROL, 32'h61);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_pins;
      t_convert(asc_pkg::CLKSEL_DIV2, int'(asc_pkg::RATIO_DIV2), 0, 1'b1);
      t_convert(asc_pkg::CLKSEL_DIV8, int'(asc_pkg::RATIO_DIV8), 1, 1'b1);
      t_convert(asc_pkg::CLKSEL_DIV32, int'(asc_pkg::RATIO_DIV32), 2, 1'b1);
      t_irq;
      t_stall;
      give_verdict;
   end

   // The whole run needs well under ten thousand cycles.
   initial begin
      repeat (60000) @(posedge clk);
      badCount++;
      give_verdict;
   end
endmodule
